// [testbench/test_aostw_top.sv]
// Self-checking bench for the always-on sleep timer register port
`default_nettype none

module test_aostw_top;
  timeunit 1ns;
  timeprecision 1ps;
  import aostw_pkg::*;

  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic clk_in = 1'b0; // 10 MHz clock
  logic sys_rst_in = 1'b1; // Reset, held at start
  logic [31:0] reg_addr_in = 32'h00000000; // Bus address
  logic [31:0] reg_wdata_in = 32'h00000000; // Bus write data
  logic reg_wr_in = 1'b0; // Write strobe
  logic reg_rd_in = 1'b0; // Read strobe
  logic [31:0] reg_rdata_out; // Read data
  logic irq_out; // Level interrupt
  logic cpu_wake_out; // Processor wake pulse
  logic radio_wake_out; // Radio wake pulse
  int n_mismatch = 0; // Mismatches seen
  int n_checks = 0; // Comparisons made
  int n_cpu = 0; // Processor wake pulses counted
  int n_rad = 0; // Radio wake pulses counted
  int cpu_base = 0; // Processor pulse count at scenario start
  int rad_base = 0; // Radio pulse count at scenario start
  logic [31:0] seed = 32'h0001690b; // Random state, 92427
  logic [31:0] ival; // Interval under test
  logic [31:0] rd_a; // First live sample
  logic [31:0] rd_b; // Second live sample

  always #50 clk_in = ~clk_in; // 100 ns period

  aostw_top u_aostw_top (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .irq_out(irq_out),
    .cpu_wake_out(cpu_wake_out),
    .radio_wake_out(radio_wake_out)
  );

  // Pulse counters; sampling at the edge catches each one-cycle pulse once
  always @(posedge clk_in) begin
    if (!sys_rst_in && cpu_wake_out === 1'b1) n_cpu <= n_cpu + 1;
    if (!sys_rst_in && radio_wake_out === 1'b1) n_rad <= n_rad + 1;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Xorshift keeps the run repeatable with a fixed start
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Expected pulses for one expiry: the enable bit at pos
  function automatic logic [31:0] wake_exp(input int w, input int pos);
    return 32'((w >> pos) & 1);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write; the slave never stalls
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // One-cycle read; data stand only in the following cycle
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  task automatic rd_check(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    check(what, d, exp);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_check("load reset", AOSTW_ADDR_LOAD, 32'h00000000);
    rd_check("count reset", AOSTW_ADDR_REMAIN, 32'h00000000);
    rd_check("wake reset", AOSTW_ADDR_WAKE, 32'h00000000);
    rd_check("unmapped", 32'h4000d008, 32'h00000000);
    bus_wr(AOSTW_ADDR_WAKE, 32'h000000ff);
    rd_check("wake spare bits", AOSTW_ADDR_WAKE, 32'h00000003);
    seed = next_rnd(seed);
    bus_wr(AOSTW_ADDR_REMAIN, seed);
    rd_check("count write ignored", AOSTW_ADDR_REMAIN, 32'h00000000);
    bus_wr(AOSTW_ADDR_MASK, 32'h00000001);
    rd_check("mask readback", AOSTW_ADDR_MASK, 32'h00000001);
    // One-shot expiry under every wake enable combination
    for (int w = 0; w < 4; w++) begin
      bus_wr(AOSTW_ADDR_WAKE, 32'(w));
      seed = next_rnd(seed);
      ival = 32'h3 + (seed % 8);
      cpu_base = n_cpu;
      rad_base = n_rad;
      bus_wr(AOSTW_ADDR_LOAD, ival);
      rd_check("load readback", AOSTW_ADDR_LOAD, ival);
      repeat (ival + 6) @(posedge clk_in);
      #1;
      check("cpu wake count", 32'(n_cpu - cpu_base), wake_exp(w, AOSTW_WAKE_CPU_BIT));
      check("radio wake count", 32'(n_rad - rad_base), wake_exp(w, AOSTW_WAKE_RADIO_BIT));
      check("irq on expiry", {31'h0, irq_out}, 32'h1);
      rd_check("one-shot stop", AOSTW_ADDR_REMAIN, 32'h00000000);
      bus_wr(AOSTW_ADDR_STAT, 32'h00000001);
      repeat (2) @(posedge clk_in);
      #1;
      check("irq cleared", {31'h0, irq_out}, 32'h0);
    end
    // Masked expiry keeps irq low but sets status
    bus_wr(AOSTW_ADDR_MASK, 32'h00000000);
    bus_wr(AOSTW_ADDR_LOAD, 32'h00000003);
    repeat (8) @(posedge clk_in);
    #1;
    check("masked irq", {31'h0, irq_out}, 32'h0);
    rd_check("status sticky", AOSTW_ADDR_STAT, 32'h00000001);
    bus_wr(AOSTW_ADDR_STAT, 32'h00000001);
    // Live count in one-shot: two reads two cycles apart
    bus_wr(AOSTW_ADDR_LOAD, 32'h00000040);
    bus_rd(AOSTW_ADDR_REMAIN, rd_a);
    bus_rd(AOSTW_ADDR_REMAIN, rd_b);
    check("live one-shot", rd_a - rd_b, 32'h00000002);
    // Reload: three expiries in three and a half periods, live meanwhile
    bus_wr(AOSTW_ADDR_MODE, 32'h00000001);
    rd_check("mode readback", AOSTW_ADDR_MODE, 32'h00000001);
    bus_wr(AOSTW_ADDR_WAKE, 32'h00000001);
    seed = next_rnd(seed);
    ival = 32'h8 + (seed % 5);
    cpu_base = n_cpu;
    bus_wr(AOSTW_ADDR_LOAD, ival);
    bus_rd(AOSTW_ADDR_REMAIN, rd_a);
    bus_rd(AOSTW_ADDR_REMAIN, rd_b);
    check("live reload", rd_a - rd_b, 32'h00000002);
    repeat (3 * ival + ival / 2 - 4) @(posedge clk_in);
    #1;
    check("reload expiries", 32'(n_cpu - cpu_base), 32'h00000003);
    bus_wr(AOSTW_ADDR_LOAD, 32'h00000000);
    rd_check("zero interval stops", AOSTW_ADDR_REMAIN, 32'h00000000);
    // Mid-run reset clears wake enables and stops a running count
    bus_wr(AOSTW_ADDR_WAKE, 32'h00000003);
    bus_wr(AOSTW_ADDR_LOAD, 32'h00000020);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_check("wake after reset", AOSTW_ADDR_WAKE, 32'h00000000);
    rd_check("count after reset", AOSTW_ADDR_REMAIN, 32'h00000000);
    report_and_stop();
  end

  // Hard stop in case the sequence hangs
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    report_and_stop();
  end
endmodule

`default_nettype wire

// [verilog/aostw_pkg.sv]
// Constants shared by the always-on sleep timer and its register port
`default_nettype none

package aostw_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [31:0] AOSTW_ADDR_LOAD = 32'h4000d000; // Interval value
  localparam logic [31:0] AOSTW_ADDR_MODE = 32'h4000d004; // Counting mode
  localparam logic [31:0] AOSTW_ADDR_REMAIN = 32'h4000d00c; // Live count
  localparam logic [31:0] AOSTW_ADDR_STAT = 32'h4000d010; // Sticky events
  localparam logic [31:0] AOSTW_ADDR_MASK = 32'h4000d014; // Event mask
  localparam logic [31:0] AOSTW_ADDR_WAKE = 32'h4000e00c; // Wake sources

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AOSTW_MODE_RELOAD_BIT = 0; // 1 = reload, 0 = one-shot
  localparam int AOSTW_STAT_EXPIRE_BIT = 0; // Counter reached zero
  localparam int AOSTW_WAKE_CPU_BIT = 0; // Processor wake allow
  localparam int AOSTW_WAKE_RADIO_BIT = 1; // Radio wake allow
  localparam int AOSTW_WAKE_WIDTH = 8; // Wake register width

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] AOSTW_LOAD_RST = 32'h00000000; // Interval
  localparam logic [31:0] AOSTW_REMAIN_RST = 32'h00000000; // Live count
  localparam logic [7:0] AOSTW_WAKE_RST = 8'h00; // No wake sources
  localparam logic AOSTW_MODE_RST = 1'b0; // One-shot
  localparam logic AOSTW_BIT_RST = 1'b0; // Status and mask bits

  // ----------------------------------------
  // Counter states
  // ----------------------------------------
  typedef enum logic {
    AOSTW_ST_IDLE, // Stopped, count holds
    AOSTW_ST_COUNT // Decrementing
  } aostw_state_e;

endpackage

`default_nettype wire

// [verilog/aostw_top.sv]
// Always-on sleep timer: interval down-counter, interrupt and wake control
// Overview of operation
// - Writable 32-bit interval loaded into down-counter
// - Counter decrements; interrupt when it reaches zero
// - Readable count is live in both modes
// - Count read-only, resets zero, writes ignored
// - Wake bit 1 gates radio wake-up
// - Wake bit 0 gates processor wake-up
// - Wake register resets zero, no wake-up
`default_nettype none

module aostw_top
  import aostw_pkg::*;
(
  input wire logic clk_in, // 10 MHz system clock
  input wire logic sys_rst_in, // Synchronous reset, active high
  input wire logic [31:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Register write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe
  output logic irq_out, // Level interrupt
  output logic cpu_wake_out, // Processor wake pulse
  output logic radio_wake_out // Radio wake pulse
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  aostw_state_e state; // Counter state
  aostw_state_e next_state; // Next counter state
  logic [31:0] interval; // Programmed interval
  logic [31:0] next_interval; // Next interval
  logic [31:0] remain; // Live remaining count
  logic [31:0] next_remain; // Next remaining count
  logic reload_mode; // Reload when set
  logic next_reload_mode; // Next mode
  logic [AOSTW_WAKE_WIDTH-1:0] wake_ctrl; // Wake source enables
  logic [AOSTW_WAKE_WIDTH-1:0] next_wake_ctrl; // Next wake enables
  logic expire_stat; // Sticky expiry status
  logic next_expire_stat; // Next status
  logic expire_mask; // Interrupt mask, 1 = enabled
  logic next_expire_mask; // Next mask
  logic [31:0] next_rdata; // Next read data
  logic next_irq; // Next interrupt level
  logic next_cpu_wake; // Next processor wake
  logic next_radio_wake; // Next radio wake

  // ----------------------------------------
  // Decoded strobes
  // ----------------------------------------
  logic wr_load; // Interval write
  logic wr_mode; // Mode write
  logic wr_stat; // Status clear write
  logic wr_mask; // Mask write
  logic wr_wake; // Wake control write
  logic expire; // Count reaches zero this cycle

  // Address match, used by every write decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // Write decode
  always_comb begin
    wr_load = reg_wr_in && hit(reg_addr_in, AOSTW_ADDR_LOAD);
    wr_mode = reg_wr_in && hit(reg_addr_in, AOSTW_ADDR_MODE);
    wr_stat = reg_wr_in && hit(reg_addr_in, AOSTW_ADDR_STAT);
    wr_mask = reg_wr_in && hit(reg_addr_in, AOSTW_ADDR_MASK);
    wr_wake = reg_wr_in && hit(reg_addr_in, AOSTW_ADDR_WAKE);
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------

  // Expiry when the last unit is counted off
  // Deciding on one, not zero, makes status and a zero count appear together
  assign expire = (state == AOSTW_ST_COUNT) && (remain == 32'h00000001);

  // Next counter values
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_interval = interval;
    if (wr_load) begin
      // New interval restarts counting at once
      next_interval = reg_wdata_in;
      next_remain = reg_wdata_in;
      if (reg_wdata_in != 32'h00000000) begin
        next_state = AOSTW_ST_COUNT;
      end else begin
        // Zero interval would never expire
        next_state = AOSTW_ST_IDLE;
      end
    end else if (expire) begin
      if (reload_mode && (interval != 32'h00000000)) begin
        next_remain = interval;
      end else begin
        next_remain = 32'h00000000;
        next_state = AOSTW_ST_IDLE;
      end
    end else if (state == AOSTW_ST_COUNT) begin
      next_remain = remain - 32'h00000001;
    end
  end

  // Counter registers
  // Reset parks the counter idle at zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= AOSTW_ST_IDLE;
      remain <= AOSTW_REMAIN_RST;
      interval <= AOSTW_LOAD_RST;
    end else begin
      state <= next_state;
      remain <= next_remain;
      interval <= next_interval;
    end
  end

  // ----------------------------------------
  // Configuration and events
  // ----------------------------------------

  // Next configuration, status and outputs
  always_comb begin
    next_reload_mode = reload_mode;
    next_wake_ctrl = wake_ctrl;
    next_expire_mask = expire_mask;
    next_expire_stat = expire_stat;
    if (wr_mode) begin
      next_reload_mode = reg_wdata_in[AOSTW_MODE_RELOAD_BIT];
    end
    if (wr_wake) begin
      // Only the two documented enables are kept
      next_wake_ctrl = AOSTW_WAKE_RST;
      next_wake_ctrl[AOSTW_WAKE_CPU_BIT] = reg_wdata_in[AOSTW_WAKE_CPU_BIT];
      next_wake_ctrl[AOSTW_WAKE_RADIO_BIT] = reg_wdata_in[AOSTW_WAKE_RADIO_BIT];
    end
    if (wr_mask) begin
      next_expire_mask = reg_wdata_in[AOSTW_STAT_EXPIRE_BIT];
    end
    // Write one clears; a same-cycle expiry wins
    if (wr_stat && reg_wdata_in[AOSTW_STAT_EXPIRE_BIT]) begin
      next_expire_stat = 1'b0;
    end
    if (expire) begin
      next_expire_stat = 1'b1;
    end
    next_irq = next_expire_stat && next_expire_mask;
    // Wake pulses follow the enables in force at expiry
    next_cpu_wake = expire && wake_ctrl[AOSTW_WAKE_CPU_BIT];
    next_radio_wake = expire && wake_ctrl[AOSTW_WAKE_RADIO_BIT];
  end

  // Configuration registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reload_mode <= AOSTW_MODE_RST;
      wake_ctrl <= AOSTW_WAKE_RST;
      expire_mask <= AOSTW_BIT_RST;
      expire_stat <= AOSTW_BIT_RST;
      irq_out <= 1'b0;
      cpu_wake_out <= 1'b0;
      radio_wake_out <= 1'b0;
    end else begin
      reload_mode <= next_reload_mode;
      wake_ctrl <= next_wake_ctrl;
      expire_mask <= next_expire_mask;
      expire_stat <= next_expire_stat;
      irq_out <= next_irq;
      cpu_wake_out <= next_cpu_wake;
      radio_wake_out <= next_radio_wake;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------

  // Read mux; unmapped addresses and idle cycles give zero
  // Zero off-strobe keeps stale data off the bus
  always_comb begin
    next_rdata = 32'h00000000;
    if (!reg_rd_in) begin
      next_rdata = 32'h00000000;
    end else if (hit(reg_addr_in, AOSTW_ADDR_LOAD)) begin
      next_rdata = interval;
    end else if (hit(reg_addr_in, AOSTW_ADDR_MODE)) begin
      next_rdata[AOSTW_MODE_RELOAD_BIT] = reload_mode;
    end else if (hit(reg_addr_in, AOSTW_ADDR_REMAIN)) begin
      next_rdata = remain;
    end else if (hit(reg_addr_in, AOSTW_ADDR_STAT)) begin
      next_rdata[AOSTW_STAT_EXPIRE_BIT] = expire_stat;
    end else if (hit(reg_addr_in, AOSTW_ADDR_MASK)) begin
      next_rdata[AOSTW_STAT_EXPIRE_BIT] = expire_mask;
    end else if (hit(reg_addr_in, AOSTW_ADDR_WAKE)) begin
      next_rdata[AOSTW_WAKE_WIDTH-1:0] = wake_ctrl;
    end
  end

  // Read data register, valid only the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  a_interval_load: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_load |=> (remain == $past(reg_wdata_in)) && (interval == $past(reg_wdata_in)))
    else $error("Interval write did not load counter");

  a_count_down: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == AOSTW_ST_COUNT) && (remain > 32'h00000001) && !wr_load
    |=> remain == $past(remain) - 32'h00000001)
    else $error("Counter did not decrement by one");

  a_expire_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    expire && !wr_mask |=> expire_stat && (irq_out == expire_mask))
    else $error("Expiry did not set status or interrupt");

  a_remain_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    reg_rd_in && (reg_addr_in == AOSTW_ADDR_REMAIN) |=> reg_rdata_out == $past(remain))
    else $error("Read of live count wrong");

  a_remain_ro: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    reg_wr_in && (reg_addr_in == AOSTW_ADDR_REMAIN) && (state == AOSTW_ST_IDLE)
    |=> remain == $past(remain))
    else $error("Write changed read-only count");

  a_radio_wake: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    radio_wake_out == ($past(expire) && $past(wake_ctrl[AOSTW_WAKE_RADIO_BIT])))
    else $error("Radio wake not gated by its enable");

  a_cpu_wake: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    cpu_wake_out == ($past(expire) && $past(wake_ctrl[AOSTW_WAKE_CPU_BIT])))
    else $error("Processor wake not gated by its enable");

  a_wake_reset: assert property (@(posedge clk_in)
    sys_rst_in |=> (wake_ctrl == AOSTW_WAKE_RST) && !cpu_wake_out && !radio_wake_out)
    else $error("Wake control not cleared by reset");

  a_oneshot_stop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    expire && !reload_mode && !wr_load
    |=> (remain == 32'h00000000) && (state == AOSTW_ST_IDLE)
    ##1 ((remain == 32'h00000000) || $past(wr_load)))
    else $error("One-shot did not stop at zero");

  a_reload_go: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    expire && reload_mode && !wr_load && (interval != 32'h00000000)
    |=> (remain == $past(interval)) && (state == AOSTW_ST_COUNT))
    else $error("Reload mode did not reload interval");

  // ----------------------------------------
  // Assertions on status, counter and wake register
  // ----------------------------------------

  // Level interrupt tracks status and mask with no extra delay
  a_irq_level: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    irq_out == (expire_stat && expire_mask))
    else $error("Interrupt level not status and mask");

  // Status stays set until software writes a one to it
  a_stat_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    expire_stat && !(wr_stat && reg_wdata_in[AOSTW_STAT_EXPIRE_BIT]) |=> expire_stat)
    else $error("Expiry status dropped without a clear");

  // Write one clears status when no expiry competes
  a_stat_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_stat && reg_wdata_in[AOSTW_STAT_EXPIRE_BIT] && !expire |=> !expire_stat)
    else $error("Expiry status not cleared by write one");

  // A running count never sits at zero, so expiry cannot be missed
  a_count_nonzero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == AOSTW_ST_COUNT) |-> (remain != 32'h00000000))
    else $error("Running counter reached zero without expiry");

  // Writing a zero interval parks the counter
  a_zero_stop: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_load && (reg_wdata_in == 32'h00000000)
    |=> (state == AOSTW_ST_IDLE) && (remain == 32'h00000000))
    else $error("Zero interval did not stop counter");

  // Stopped counter holds until the next interval write
  // This also keeps a finished one-shot at zero
  a_idle_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state == AOSTW_ST_IDLE) && !wr_load
    |=> (state == AOSTW_ST_IDLE) && (remain == $past(remain)))
    else $error("Idle counter moved without a load");

  // Spare wake bits never hold a one
  a_wake_spare: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wake_ctrl & 8'hfc) == 8'h00)
    else $error("Spare wake control bit set");

endmodule

`default_nettype wire
